// file: reg_bus_if.sv
/*
  Internal register access carrier between the bus port and the
  register file. Assumes one write pulse per bus write.
*/
`timescale 1ns/1ns
interface reg_bus_if;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic        wr;
    logic [31:0] rdata;

    modport port (output addr, output wdata, output be, output wr, input rdata);
    modport regs (input addr, input wdata, input be, input wr, output rdata);
endinterface

// file: reset_status_and_peripheral_enable.sv
/*
  Reset cause recorder and per-peripheral reset control with a
  Wishbone register port and a reset cause interrupt.
  Assumes event requests arrive asynchronously as levels and the
  power-on reset drives arst_n_i.
*/
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ns

// Operation
// R1: A status flag reads one after a reset from its source, else zero.
// R2: Writing one to a status flag clears it.
// R3: The cause status register is eight bits, one per source.
// R4: Bit 7 power-on down to bit 0 low voltage; only bit 7 set after power-on.
// R5: Mask bit one lets an event reset reach its peripheral.
// R6: Mask bit zero shields the peripheral from event resets.
// R7: First mask register: timers, GPIO, DMA, port control, watchdog, flash, system.
// R8: Second mask register: analog front end, ADCs, PWM, UARTs, I2C, SPI.
// R9: A peripheral stays in reset until its enable bit is written one.
// R10: Writing enable zero puts the peripheral back into reset.
// R11: First enable register: timers, GPIO, DMA; bits 3 to 0 reserved.
// R12: Second enable register uses the second mask register layout.
// R13: Only a source with its enable bit one causes an event reset.
// R14: Writing zero to a status flag leaves it unchanged.
// R15: Reserved mask and enable bits read zero and ignore writes.
module reset_status_and_peripheral_enable #(
    parameter int EVENT_CYCLES = rst_ctrl_pkg::EVENT_RST_CYC
) (
    input  wire logic                               clk_i,            // 10 MHz
    input  wire logic                               arst_n_i,         // Power-on reset, low
    input  wire logic                               wb_cyc_i,         // Wishbone cycle
    input  wire logic                               wb_stb_i,         // Wishbone strobe
    input  wire logic                               wb_we_i,          // Wishbone write
    input  wire logic [31:0]                        wb_adr_i,         // Byte address
    input  wire logic [3:0]                         wb_sel_i,         // Byte lanes
    input  wire logic [31:0]                        wb_dat_i,         // Write data
    output logic      [31:0]                        wb_dat_o,         // Read data
    output logic                                    wb_ack_o,         // Acknowledge
    input  wire logic [rst_ctrl_pkg::NUM_EVENT-1:0] reset_event_i,    // Async event requests
    output logic      [31:0]                        periph_rst_one_o, // Resets, first group
    output logic      [31:0]                        periph_rst_two_o, // Resets, second group
    output logic                                    irq_o             // Cause interrupt
);

    import rst_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Types and signals

    typedef enum logic [1:0] {
        EV_IDLE = 2'b01,
        EV_HOLD = 2'b10
    } ev_state_t;

    localparam logic [7:0] CNT_LOAD = 8'(EVENT_CYCLES);

    reg_bus_if rb ();

    logic [NUM_EVENT-1:0] meta_q;
    logic [NUM_EVENT-1:0] sync_q;
    logic [NUM_EVENT-1:0] prev_q;
    logic [NUM_CAUSE-1:0] rise;

    logic [7:0]  src_en_q;
    logic [7:0]  status_q;
    logic [7:0]  status_d;
    logic [7:0]  status_clr;
    logic [7:0]  irq_mask_q;
    logic [31:0] mask_one_q;
    logic [31:0] mask_two_q;
    logic [31:0] en_one_q;
    logic [31:0] en_two_q;

    logic        wr_src_en;
    logic        wr_status;
    logic        wr_irq_mask;
    logic        wr_mask_one;
    logic        wr_mask_two;
    logic        wr_en_one;
    logic        wr_en_two;
    logic [31:0] lanes;
    logic [31:0] rdata;

    ev_state_t   state_q;
    ev_state_t   state_d;
    logic [7:0]  cnt_q;
    logic        event_on;

    ////////////////////////////////////////////////////////////////////////
    // Bus port

    wb_reg_port u_port (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .rb       (rb.port)
    );

    assign lanes = {{8{rb.be[3]}}, {8{rb.be[2]}}, {8{rb.be[1]}}, {8{rb.be[0]}}};

    assign wr_src_en   = rb.wr & (rb.addr == ADDR_SRC_EN);
    assign wr_status   = rb.wr & (rb.addr == ADDR_STATUS);
    assign wr_irq_mask = rb.wr & (rb.addr == ADDR_IRQ_MASK);
    assign wr_mask_one = rb.wr & (rb.addr == ADDR_MASK_ONE);
    assign wr_mask_two = rb.wr & (rb.addr == ADDR_MASK_TWO);
    assign wr_en_one   = rb.wr & (rb.addr == ADDR_EN_ONE);
    assign wr_en_two   = rb.wr & (rb.addr == ADDR_EN_TWO);

    ////////////////////////////////////////////////////////////////////////
    // Event synchronisers

    genvar g;
    generate
        for (g = 0; g < NUM_EVENT; g++) begin : g_sync
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                    prev_q[g] <= 1'b0;
                end else begin
                    meta_q[g] <= reset_event_i[g];
                    sync_q[g] <= meta_q[g];
                    prev_q[g] <= sync_q[g];
                end
            end
            // Rising request counts only while its source is enabled
            assign rise[g] = sync_q[g] & ~prev_q[g] & src_en_q[g]; // R13
        end
    endgenerate

    // Power-on has no request line; the reset itself records it
    assign rise[BIT_POWER_ON] = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Source enable register

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            src_en_q <= SRC_EN_RST;
        end else if (wr_src_en & rb.be[0]) begin
            src_en_q <= {1'b0, rb.wdata[6:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset cause status

    // Only ones clear, and a new cause beats a clear in the same cycle
    assign status_clr = wr_status ? (rb.wdata[7:0] & lanes[7:0]) : 8'h00; // R2 R14
    assign status_d   = (status_q & ~status_clr) | rise; // R1

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status_q <= STATUS_RST; // R4
        end else begin
            status_q <= status_d; // R3
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_mask_q <= IRQ_MASK_RST;
        end else if (wr_irq_mask & rb.be[0]) begin
            irq_mask_q <= rb.wdata[7:0];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_d & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Peripheral reset masks

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mask_one_q <= MASK_ONE_RST;
        end else if (wr_mask_one) begin
            mask_one_q <= ((mask_one_q & ~lanes) | (rb.wdata & lanes)) & MASK_ONE_BITS; // R7 R15
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mask_two_q <= MASK_TWO_RST;
        end else if (wr_mask_two) begin
            mask_two_q <= ((mask_two_q & ~lanes) | (rb.wdata & lanes)) & MASK_TWO_BITS; // R8 R15
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Peripheral function enables

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            en_one_q <= EN_ONE_RST;
        end else if (wr_en_one) begin
            en_one_q <= ((en_one_q & ~lanes) | (rb.wdata & lanes)) & EN_ONE_BITS; // R11 R15
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            en_two_q <= EN_TWO_RST;
        end else if (wr_en_two) begin
            en_two_q <= ((en_two_q & ~lanes) | (rb.wdata & lanes)) & EN_TWO_BITS; // R12 R15
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event reset pulse

    always_comb begin
        state_d = state_q;
        case (state_q)
            EV_IDLE: begin
                if (|rise) begin
                    state_d = EV_HOLD;
                end
            end
            EV_HOLD: begin
                if ((cnt_q == 8'h01) && !(|rise)) begin
                    state_d = EV_IDLE;
                end
            end
            default: begin
                state_d = EV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= EV_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // A fresh cause restarts the full pulse
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= 8'h00;
        end else if (|rise) begin
            cnt_q <= CNT_LOAD;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    assign event_on = (state_q == EV_HOLD);

    ////////////////////////////////////////////////////////////////////////
    // Peripheral reset outputs

    // Event reaches only masked-in units; disabled units stay in reset
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            periph_rst_one_o <= MASK_ONE_BITS;
            periph_rst_two_o <= MASK_TWO_BITS;
        end else begin
            periph_rst_one_o <= ({32{event_on}} & mask_one_q) // R5 R6
                              | (EN_ONE_BITS & ~en_one_q);     // R9 R10
            periph_rst_two_o <= ({32{event_on}} & mask_two_q) // R5 R6
                              | (EN_TWO_BITS & ~en_two_q);     // R9 R10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    always_comb begin
        rdata = 32'h0000_0000;
        case (rb.addr)
            ADDR_SRC_EN: begin
                rdata = {24'h00_0000, src_en_q};
            end
            ADDR_STATUS: begin
                rdata = {24'h00_0000, status_q};
            end
            ADDR_IRQ_MASK: begin
                rdata = {24'h00_0000, irq_mask_q};
            end
            ADDR_MASK_ONE: begin
                rdata = mask_one_q;
            end
            ADDR_MASK_TWO: begin
                rdata = mask_two_q;
            end
            ADDR_EN_ONE: begin
                rdata = en_one_q;
            end
            ADDR_EN_TWO: begin
                rdata = en_two_q;
            end
            default: begin
                rdata = 32'h0000_0000;
            end
        endcase
    end

    assign rb.rdata = rdata;

endmodule // reset_status_and_peripheral_enable

// file: reset_status_and_peripheral_enable_assertions.sv
/*
  Port checker for the reset status and peripheral enable block.
  Assumes binding to the top module and one clock domain.
*/
`timescale 1ns/1ns
module rsp_assertions #(
    parameter int EVENT_CYCLES = rst_ctrl_pkg::EVENT_RST_CYC
) (
    input wire logic                               clk_i,            // Clock
    input wire logic                               arst_n_i,         // Reset, low
    input wire logic                               wb_cyc_i,         // Cycle
    input wire logic                               wb_stb_i,         // Strobe
    input wire logic                               wb_we_i,          // Write
    input wire logic [31:0]                        wb_adr_i,         // Address
    input wire logic [3:0]                         wb_sel_i,         // Lanes
    input wire logic [31:0]                        wb_dat_i,         // Write data
    input wire logic [31:0]                        wb_dat_o,         // Read data
    input wire logic                               wb_ack_o,         // Ack
    input wire logic [rst_ctrl_pkg::NUM_EVENT-1:0] reset_event_i,    // Events
    input wire logic [31:0]                        periph_rst_one_o, // Resets one
    input wire logic [31:0]                        periph_rst_two_o, // Resets two
    input wire logic                               irq_o             // Interrupt
);
import rst_ctrl_pkg::*;
logic [7:0] since_q;
logic [7:0] hi_q;
default clocking @(posedge clk_i); endclocking
default disable iff (!arst_n_i);
////////////////////////////////////////////////////////////////
// Cycles since any event request, and length of system reset pulse
always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) since_q <= 8'h00;
    else if (|reset_event_i) since_q <= 8'h00;
    else if (since_q != 8'hff) since_q <= since_q + 8'h01;
end
always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) hi_q <= 8'(EVENT_CYCLES);
    else if (!periph_rst_one_o[0]) hi_q <= 8'h00;
    else if (hi_q != 8'hff) hi_q <= hi_q + 8'h01;
end
////////////////////////////////////////////////////////////////
property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
property p_ack_req; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
a_ack_req: assert property (p_ack_req) else $error("request not acked");
property p_one_bits; (periph_rst_one_o & ~MASK_ONE_BITS) == 32'h0; endproperty
a_one_bits: assert property (p_one_bits) else $error("reset on unused bit, group one");
property p_two_bits; (periph_rst_two_o & ~MASK_TWO_BITS) == 32'h0; endproperty
a_two_bits: assert property (p_two_bits) else $error("reset on unused bit, group two");
property p_cause; $rose(periph_rst_one_o[0]) |-> since_q <= 8'd6; endproperty
a_cause: assert property (p_cause) else $error("event reset without event");
property p_len; $fell(periph_rst_one_o[0]) |-> hi_q >= 8'(EVENT_CYCLES); endproperty
a_len: assert property (p_len) else $error("event reset too short");
// Quiet window covers sync latency plus the full pulse length
property p_quiet; since_q >= 8'(EVENT_CYCLES + 8) |-> (periph_rst_one_o & ~EN_ONE_BITS) == 32'h0; endproperty
a_quiet: assert property (p_quiet) else $error("reset without event");
property p_irq_off;
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_IRQ_MASK && wb_dat_i[7:0] == 8'h00
        |=> ##1 !irq_o;
endproperty
a_irq_off: assert property (p_irq_off) else $error("irq high while masked");
c_event: cover property ($rose(periph_rst_one_o[0]));
c_irq: cover property ($rose(irq_o));
c_write: cover property (wb_ack_o && wb_we_i);
endmodule // rsp_assertions

// file: reset_status_and_peripheral_enable_tb_top.sv
/*
  Self-checking bench for the reset status block.
  Assumes the package and design files are compiled first.
*/
`timescale 1ns/1ns
module reset_status_and_peripheral_enable_tb_top;
import rst_ctrl_pkg::*;
localparam int EVENT_CYCLES = 2;
logic        clk_i, arst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, irq_o, wb_ack_o;
logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, periph_rst_one_o, periph_rst_two_o;
logic [3:0]  wb_sel_i;
logic [6:0]  reset_event_i;
logic [31:0] seed, rd, r, m1, m2, e1, e2;
int          errors, checks_done, i, k;

reset_status_and_peripheral_enable #(.EVENT_CYCLES(EVENT_CYCLES)) dut (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .reset_event_i(reset_event_i), .periph_rst_one_o(periph_rst_one_o),
    .periph_rst_two_o(periph_rst_two_o), .irq_o(irq_o));

initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
end
////////////////////////////////////////////////////////////////
function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
endfunction
// Expected resets: masked-in event part plus units not enabled
function automatic logic [31:0] exp_rst(input logic [31:0] m, input logic [31:0] e, input logic [31:0] b);
    return m | (~e & b);
endfunction
task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
endtask
task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
        errors++;
        $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
endtask
task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d);
    int t;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    t = 0;
    // Ack and read data are taken at the rising edge, before it updates them
    do begin
        @(posedge clk_i);
        t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    if (wb_ack_o !== 1'b1) begin
        errors++;
        test_done();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
endtask
task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
endtask
task automatic wait_irq();
    int t;
    t = 0;
    @(negedge clk_i);
    while (irq_o !== 1'b1 && t < 10) begin
        @(negedge clk_i);
        t++;
    end
    if (t >= 10) begin
        errors++;
        test_done();
    end
endtask
task automatic quiet_event(input logic [6:0] ev);
    @(posedge clk_i);
    reset_event_i <= ev;
    repeat (8) @(negedge clk_i);
    chk("irq", 32'h0, {31'h0, irq_o});
    @(posedge clk_i);
    reset_event_i <= 7'h00;
endtask
////////////////////////////////////////////////////////////////
initial begin
    errors = 0;
    checks_done = 0;
    seed = 32'd33;
    arst_n_i = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    reset_event_i = 7'h00;
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    // periph_rst_one_o leaves its reset value at the first edge after release
    repeat (2) @(negedge clk_i);
    chk("rst_one", exp_rst(32'h0, 32'h0, EN_ONE_BITS), periph_rst_one_o);
    chk("rst_two", exp_rst(32'h0, 32'h0, EN_TWO_BITS), periph_rst_two_o);
    rchk("status", ADDR_STATUS, 32'h80);
    rchk("mask_one", ADDR_MASK_ONE, MASK_ONE_BITS);
    rchk("mask_two", ADDR_MASK_TWO, MASK_TWO_BITS);
    rchk("en_one", ADDR_EN_ONE, 32'h0);
    rchk("en_two", ADDR_EN_TWO, 32'h0);
    rchk("src_en", ADDR_SRC_EN, 32'h49);
    wb(1'b1, 32'h4000_0030, 32'hffff_ffff);
    rchk("unmapped", 32'h4000_0030, 32'h0);
    wb(1'b1, ADDR_STATUS, 32'h0);
    rchk("status", ADDR_STATUS, 32'h80);
    wb(1'b1, ADDR_STATUS, 32'h80);
    rchk("status", ADDR_STATUS, 32'h0);
    // All ones, all zeros, then random patterns
    for (k = 0; k < 6; k++) begin
        r = (k == 0) ? 32'hffff_ffff : (k == 1) ? 32'h0 : xs();
        wb(1'b1, ADDR_EN_ONE, r);
        rchk("en_one", ADDR_EN_ONE, r & EN_ONE_BITS);
        chk("rst_one", exp_rst(32'h0, r, EN_ONE_BITS), periph_rst_one_o);
        wb(1'b1, ADDR_EN_TWO, ~r);
        rchk("en_two", ADDR_EN_TWO, ~r & EN_TWO_BITS);
        chk("rst_two", exp_rst(32'h0, ~r, EN_TWO_BITS), periph_rst_two_o);
        wb(1'b1, ADDR_MASK_ONE, r);
        rchk("mask_one", ADDR_MASK_ONE, r & MASK_ONE_BITS);
        wb(1'b1, ADDR_MASK_TWO, ~r);
        rchk("mask_two", ADDR_MASK_TWO, ~r & MASK_TWO_BITS);
    end
    wb(1'b1, ADDR_SRC_EN, 32'h7f);
    wb(1'b1, ADDR_IRQ_MASK, 32'hff);
    for (i = 0; i < 7; i++) begin
        m1 = (xs() | 32'h1) & MASK_ONE_BITS;
        m2 = xs() & MASK_TWO_BITS;
        e1 = xs();
        e2 = xs();
        wb(1'b1, ADDR_MASK_ONE, m1);
        wb(1'b1, ADDR_MASK_TWO, m2);
        wb(1'b1, ADDR_EN_ONE, e1);
        wb(1'b1, ADDR_EN_TWO, e2);
        @(posedge clk_i);
        reset_event_i <= 7'h01 << i;
        wait_irq();
        // Event reset outputs follow the status flag by one cycle
        @(negedge clk_i);
        chk("rst_one", exp_rst(m1, e1, EN_ONE_BITS), periph_rst_one_o);
        chk("rst_two", exp_rst(m2, e2, EN_TWO_BITS), periph_rst_two_o);
        @(posedge clk_i);
        reset_event_i <= 7'h00;
        rchk("status", ADDR_STATUS, 32'h1 << i);
        wb(1'b1, ADDR_STATUS, 32'hff);
        rchk("status", ADDR_STATUS, 32'h0);
        chk("irq", 32'h0, {31'h0, irq_o});
    end
    wb(1'b1, ADDR_SRC_EN, 32'h77);
    quiet_event(7'h08);
    rchk("status", ADDR_STATUS, 32'h0);
    chk("rst_one", exp_rst(32'h0, e1, EN_ONE_BITS), periph_rst_one_o);
    wb(1'b1, ADDR_IRQ_MASK, 32'h0);
    quiet_event(7'h04);
    rchk("status", ADDR_STATUS, 32'h4);
    test_done();
end
endmodule // reset_status_and_peripheral_enable_tb_top

bind reset_status_and_peripheral_enable rsp_assertions #(.EVENT_CYCLES(EVENT_CYCLES)) u_chk (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reset_event_i(reset_event_i),
    .periph_rst_one_o(periph_rst_one_o), .periph_rst_two_o(periph_rst_two_o), .irq_o(irq_o));

// file: rst_ctrl_pkg.sv
/*
  Constants for the reset status and peripheral enable block:
  register byte addresses, field layouts, reset values, timing.
  Assumes a 32-bit byte-addressed register bus.
*/
package rst_ctrl_pkg;

    localparam int NUM_CAUSE = 8;
    localparam int NUM_EVENT = 7;

    // Byte addresses
    localparam logic [31:0] ADDR_SRC_EN   = 32'h4000_0018;
    localparam logic [31:0] ADDR_STATUS   = 32'h4000_001c;
    localparam logic [31:0] ADDR_MASK_ONE = 32'h4000_0020;
    localparam logic [31:0] ADDR_MASK_TWO = 32'h4000_0024;
    localparam logic [31:0] ADDR_EN_ONE   = 32'h4000_0028;
    localparam logic [31:0] ADDR_EN_TWO   = 32'h4000_002c;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'h4000_003c;

    // Cause positions in status and source enable
    localparam int BIT_POWER_ON   = 7;
    localparam int BIT_PIN        = 6;
    localparam int BIT_CPU_REQ    = 5;
    localparam int BIT_SOFTWARE   = 4;
    localparam int BIT_WATCHDOG   = 3;
    localparam int BIT_MCLK_FAIL  = 2;
    localparam int BIT_EOSC_FAIL  = 1;
    localparam int BIT_LOW_VOLT   = 0;

    // Implemented bits of the peripheral registers
    localparam logic [31:0] MASK_ONE_BITS = 32'h030f_0f1f;
    localparam logic [31:0] MASK_TWO_BITS = 32'h00f3_0f33;
    localparam logic [31:0] EN_ONE_BITS   = 32'h030f_0f10;
    localparam logic [31:0] EN_TWO_BITS   = 32'h00f3_0f33;

    // Values after reset
    localparam logic [7:0]  SRC_EN_RST    = 8'h49;
    localparam logic [7:0]  STATUS_RST    = 8'h80;
    localparam logic [7:0]  IRQ_MASK_RST  = 8'h00;
    localparam logic [31:0] MASK_ONE_RST  = MASK_ONE_BITS;
    localparam logic [31:0] MASK_TWO_RST  = MASK_TWO_BITS;
    localparam logic [31:0] EN_ONE_RST    = 32'h0000_0000;
    localparam logic [31:0] EN_TWO_RST    = 32'h0000_0000;

    // Timing
    localparam int CLK_PERIOD_NS  = 100;
    localparam int EVENT_RST_NS   = 1000;
    localparam int EVENT_RST_CYC  = (EVENT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// file: wb_reg_port.sv
/*
  Classic Wishbone slave front end: one wait state, registered ack
  and read data. Assumes a master that holds its request until ack.
*/
`timescale 1ns/1ns
module wb_reg_port (
    input  wire logic        clk_i,     // Bus clock
    input  wire logic        arst_n_i,  // Async reset, low
    input  wire logic        wb_cyc_i,  // Cycle
    input  wire logic        wb_stb_i,  // Strobe
    input  wire logic        wb_we_i,   // Write
    input  wire logic [31:0] wb_adr_i,  // Byte address
    input  wire logic [3:0]  wb_sel_i,  // Byte lanes
    input  wire logic [31:0] wb_dat_i,  // Write data
    output logic      [31:0] wb_dat_o,  // Read data
    output logic             wb_ack_o,  // Acknowledge
    reg_bus_if.port          rb         // Register side
);

    logic req;
    logic ack_q;
    logic [31:0] dat_q;

    assign req      = wb_cyc_i & wb_stb_i;
    assign rb.addr  = wb_adr_i;
    assign rb.wdata = wb_dat_i;
    assign rb.be    = wb_sel_i;
    // Write lands on the edge where the master sees ack
    assign rb.wr    = req & wb_we_i & ack_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dat_q <= 32'h0000_0000;
        end else if (req & ~ack_q) begin
            dat_q <= rb.rdata;
        end
    end

endmodule // wb_reg_port
